// ---- logic/line_legality.sv ----
// instruction line legality and issue with buffered bus stores
// assumes sequencer re-presents a stalled line and arbiter acks stores
`timescale 1ns/10ps
module line_legality
#(
	parameter int DATA_W = line_check_pkg::DATA_W_DEF
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic line_valid,
	input wire line_check_pkg::slot_t slot0,
	input wire line_check_pkg::slot_t slot1,
	input wire logic soc_hold_j,
	input wire logic soc_hold_k,
	input wire logic [DATA_W-1:0] rf_store_data,
	input wire logic store_ack,
	output logic issue,
	output logic stall,
	output logic illegal_exc,
	output logic op_exc,
	output logic idle_req,
	output logic j_bus_busy,
	output logic k_bus_busy,
	output logic store_req,
	output logic [DATA_W-1:0] store_data
);
	import line_check_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic is_xfer(input slot_t s);
		is_xfer = (s.op == OP_XFER) || (s.op == OP_IMM);
	endfunction

	function automatic logic k_port_clash(input slot_t a, input slot_t b);
		k_port_clash = (a.op == OP_STORE_SUM) && (a.src_cls == RC_KREG) &&
			((b.op == OP_IMM) || (b.op == OP_KARITH));
	endfunction

	function automatic logic is_store(input slot_t s);
		is_store = (s.op == OP_STORE) || (s.op == OP_STORE_SUM);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// per-slot checkers

	slot_chk_if c0();
	slot_chk_if c1();
	assign c0.slot = slot0;
	assign c1.slot = slot1;
	slot_check u_chk0 (.s(c0));
	slot_check u_chk1 (.s(c1));

	////////////////////////////////////////////////////////////////////////
	// line level decisions

	store_st_t st_r;
	store_st_t st_nxt;
	logic x0, x1, need_j, need_k, kclash, same_unit, line_bad, has_store, hold, go;

	always_comb
	begin
		x0 = c0.active && is_xfer(slot0);
		x1 = c1.active && is_xfer(slot1);
		// each unit owns its bus unless yielded to system side
		need_j = (x0 && slot0.unit == UNIT_J) || (x1 && slot1.unit == UNIT_J);
		need_k = (x0 && slot0.unit == UNIT_K) || (x1 && slot1.unit == UNIT_K);
		kclash = c0.active && c1.active &&
			(k_port_clash(slot0, slot1) || k_port_clash(slot1, slot0));
		same_unit = x0 && x1 && (slot0.unit == slot1.unit);
		line_bad = c0.bad || c1.bad || kclash || same_unit;
		has_store = (c0.active && is_store(slot0)) || (c1.active && is_store(slot1));
		hold = (need_j && soc_hold_j) || (need_k && soc_hold_k) ||
			(has_store && st_r != ST_IDLE);
		go = line_valid && !line_bad && !hold;
	end

	// issue, stall and trap outcomes, one cycle after the line
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			issue <= 1'b0;
			stall <= 1'b0;
			illegal_exc <= 1'b0;
			op_exc <= 1'b0;
			idle_req <= 1'b0;
			j_bus_busy <= 1'b0;
			k_bus_busy <= 1'b0;
		end
		else
		begin
			issue <= go;
			stall <= line_valid && !line_bad && hold;
			illegal_exc <= line_valid && line_bad;
			op_exc <= go && (c0.exc || c1.exc);
			idle_req <= go && (c0.idle_req || c1.idle_req);
			j_bus_busy <= go && need_j;
			k_bus_busy <= go && need_k;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// store buffer: old value caught at second execute stage

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:
				if (go && has_store)
					st_nxt = ST_E1;
			ST_E1:
				st_nxt = ST_BUF;
			ST_BUF:
				if (store_ack)
					st_nxt = ST_IDLE;
			default:
				st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			st_r <= ST_IDLE;
		else
			st_r <= st_nxt;
	end

	// data frozen on entry to the buffer, independent of bus delay
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			store_req <= 1'b0;
			store_data <= '0;
		end
		else if (st_r == ST_E1)
		begin
			store_req <= 1'b1;
			store_data <= rf_store_data;
		end
		else if (st_r == ST_BUF && store_ack)
			store_req <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	a_bad_line_trap: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && line_bad |=> illegal_exc && !issue && !idle_req)
		else $error("bad line was not trapped");

	a_jk_pair_issue: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && x0 && x1 && slot0.unit != slot1.unit && !c0.bad && !c1.bad &&
		!soc_hold_j && !soc_hold_k |=> issue && j_bus_busy && k_bus_busy)
		else $error("j and k transfer pair did not issue together");

	a_yield_j_bus: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && need_j && soc_hold_j |=> !issue && !j_bus_busy)
		else $error("j bus used while yielded");

	a_kport_clash: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && c0.active && c1.active && slot0.op == OP_STORE_SUM &&
		slot0.src_cls == RC_KREG && slot1.op == OP_KARITH |=> illegal_exc)
		else $error("k output port clash not trapped");

	a_store_old_data: assert property (@(posedge clk) disable iff (!rstn)
		store_req && !$past(store_req) |-> store_data == $past(rf_store_data))
		else $error("buffered store data not captured at execute stage");

	a_store_held: assert property (@(posedge clk) disable iff (!rstn)
		store_req && !store_ack |=> store_req && $stable(store_data))
		else $error("buffered store changed before ack");

	a_dbg_seq_block: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && c0.active && slot0.op == OP_XFER && slot0.src_cls == RC_DBG &&
		(slot0.dst_cls == RC_SEQ || slot0.dst_cls == RC_DBG) |=> illegal_exc)
		else $error("debug register transfer not trapped");

	a_pred_false_quiet: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && !slot0.pred_true && !slot1.pred_true |=> !op_exc && !illegal_exc)
		else $error("predicated false line raised exception");

	a_option_plain_idle: assert property (@(posedge clk) disable iff (!rstn)
		go && c0.active && slot0.op == OP_IDLE && slot0.low_power_option |=> idle_req)
		else $error("idle with option not executed as idle");

	a_soc_xfer_trap: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && c1.active && slot1.op == OP_XFER && slot1.src_cls == RC_SOC &&
		slot1.dst_cls == RC_SEQ |=> illegal_exc)
		else $error("system register to sequencer not trapped");

	a_acc_same_reg: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && c0.active && slot0.op == OP_CORR_ACC &&
		slot0.acc_idx != slot0.dst_idx |=> illegal_exc && !issue)
		else $error("foreign accumulation source accepted");

	// outcome, yield, trap and buffer checks
	a_one_outcome: assert property (@(posedge clk) disable iff (!rstn)
		line_valid |=> $onehot({issue, stall, illegal_exc}))
		else $error("line did not get exactly one outcome");

	a_yield_k_bus: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && need_k && soc_hold_k |=> !issue && !k_bus_busy)
		else $error("k bus used while yielded");

	a_same_unit_trap: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && same_unit |=> illegal_exc && !issue)
		else $error("two transfers on one unit not trapped");

	a_store_stall: assert property (@(posedge clk) disable iff (!rstn)
		line_valid && has_store && st_r != ST_IDLE && !line_bad |=>
		stall && !issue)
		else $error("store line issued while buffer busy");

	a_store_capture: assert property (@(posedge clk) disable iff (!rstn)
		st_r == ST_E1 |=> store_req && store_data == $past(rf_store_data))
		else $error("store data not caught at second execute stage");

endmodule // line_legality

// ---- logic/line_check_pkg.sv ----
// shared types and constants for instruction line legality checking
// assumes the decoder upstream presents one line of two slot descriptors
package line_check_pkg;

	localparam int IDX_W = 5;
	localparam int DATA_W_DEF = 32;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_XFER = 4'h1,
		OP_IMM = 4'h2,
		OP_STORE_SUM = 4'h3,
		OP_STORE = 4'h4,
		OP_KARITH = 4'h5,
		OP_ARITH = 4'h6,
		OP_IDLE = 4'h7,
		OP_CORR_ACC = 4'h8
	} op_t;

	typedef enum logic [2:0] {
		RC_GEN = 3'h0,
		RC_SEQ = 3'h1,
		RC_DBG = 3'h2,
		RC_SOC = 3'h3,
		RC_KREG = 3'h4,
		RC_JREG = 3'h5,
		RC_PATH = 3'h6
	} reg_class_t;

	typedef enum logic {
		UNIT_J = 1'b0,
		UNIT_K = 1'b1
	} unit_t;

	typedef struct packed {
		logic valid;
		op_t op;
		unit_t unit;
		reg_class_t src_cls;
		reg_class_t dst_cls;
		logic [IDX_W-1:0] src_idx;
		logic [IDX_W-1:0] dst_idx;
		logic [IDX_W-1:0] acc_idx;
		logic low_power_option;
		logic pred_true;
		logic raw_exc;
	} slot_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_E1 = 2'b01,
		ST_BUF = 2'b10
	} store_st_t;

endpackage

// ---- logic/slot_chk_if.sv ----
// carrier between the line checker and its per-slot checkers
// assumes slot descriptors come from the package
`timescale 1ns/10ps
interface slot_chk_if;
	import line_check_pkg::*;
	slot_t slot;
	logic active;
	logic bad;
	logic exc;
	logic idle_req;
	modport user(output slot, input active, input bad, input exc, input idle_req);
	modport chk(input slot, output active, output bad, output exc, output idle_req);
endinterface

// ---- logic/slot_check.sv ----
// per-slot legality: forbidden transfers, predicate masking, idle mapping
// assumes a registered consumer; purely combinational
`timescale 1ns/10ps
module slot_check
(
	slot_chk_if.chk s
);
	import line_check_pkg::*;

	logic seq_dbg;
	logic soc_to_core;
	logic acc_bad;

	// forbidden register transfer classes
	always_comb
	begin
		seq_dbg = (s.slot.op == OP_XFER) &&
			((s.slot.src_cls == RC_SEQ && s.slot.dst_cls == RC_DBG) ||
			(s.slot.src_cls == RC_DBG && s.slot.dst_cls == RC_SEQ) ||
			(s.slot.src_cls == RC_DBG && s.slot.dst_cls == RC_DBG));
		soc_to_core = (s.slot.op == OP_XFER) && (s.slot.src_cls == RC_SOC) &&
			(s.slot.dst_cls == RC_SEQ || s.slot.dst_cls == RC_DBG);
		acc_bad = (s.slot.op == OP_CORR_ACC) && (s.slot.acc_idx != s.slot.dst_idx);
	end

	// a false predicate makes the slot a quiet no-op
	assign s.active = s.slot.valid && s.slot.pred_true;
	assign s.bad = s.active && (seq_dbg || soc_to_core || acc_bad);
	assign s.exc = s.active && s.slot.raw_exc;
	// option bit is ignored, plain idle results
	assign s.idle_req = s.active && (s.slot.op == OP_IDLE);

endmodule // slot_check

// ---- verif/store_arbiter_model.sv ----
// far-side arbiter model: acknowledges buffered stores
// assumes the bench sets the ack delay in cycles
`timescale 1ns/10ps
module store_arbiter_model
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic store_req,
	input wire logic [3:0] dly,
	output logic store_ack
);
	logic [3:0] wait_r;
	// one-cycle ack once the request has waited dly cycles
	always @(negedge clk)
	begin
		if (!rstn || !store_req || store_ack)
		begin
			store_ack <= 1'b0;
			wait_r <= 4'h0;
		end
		else if (wait_r >= dly)
			store_ack <= 1'b1;
		else
			wait_r <= wait_r + 4'h1;
	end
endmodule // store_arbiter_model

// ---- verif/line_legality_test.sv ----
// self-checking bench for the line legality unit
// assumes the arbiter model answers the store port
`timescale 1ns/10ps
module line_legality_test;
	import line_check_pkg::*;
	logic clk, rstn, line_valid, soc_hold_j, soc_hold_k, store_ack, store_req;
	logic issue, stall, illegal_exc, op_exc, idle_req, j_bus_busy, k_bus_busy, x;
	logic [31:0] rf_store_data, store_data, d, e;
	logic [3:0] dly;
	slot_t slot0, slot1, a, b, s, st, ar;
	int seed = 68701, mismatches = 0, cmp_count = 0, cycles = 0, i;
	reg_class_t fs[5] = '{RC_SEQ, RC_DBG, RC_DBG, RC_SOC, RC_SOC};
	reg_class_t fd[5] = '{RC_DBG, RC_SEQ, RC_DBG, RC_SEQ, RC_DBG};
	////////////////////////////////////////////////////////////////
	line_legality dut_u (.clk(clk), .rstn(rstn), .line_valid(line_valid), .slot0(slot0),
		.slot1(slot1), .soc_hold_j(soc_hold_j), .soc_hold_k(soc_hold_k),
		.rf_store_data(rf_store_data), .store_ack(store_ack), .issue(issue), .stall(stall),
		.illegal_exc(illegal_exc), .op_exc(op_exc), .idle_req(idle_req),
		.j_bus_busy(j_bus_busy), .k_bus_busy(k_bus_busy), .store_req(store_req),
		.store_data(store_data));
	store_arbiter_model arb_u (.clk(clk), .rstn(rstn), .store_req(store_req), .dly(dly),
		.store_ack(store_ack));
	// clock and cycle ceiling
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			mismatches++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic slot_t mk(op_t op, unit_t u, reg_class_t sc, reg_class_t dc);
		return '{1'b1, op, u, sc, dc, 5'h0, 5'h0, 5'h0, 1'b0, 1'b1, 1'b0};
	endfunction
	function automatic reg_class_t cls();
		return reg_class_t'($unsigned($random(seed)) % 7);
	endfunction
	// transfer forbidden between sequencer, debug and system registers
	function automatic logic bad(slot_t t);
		return t.valid && t.pred_true && t.op == OP_XFER
			&& ((t.dst_cls == RC_DBG && t.src_cls inside {RC_SEQ, RC_DBG, RC_SOC})
			|| (t.dst_cls == RC_SEQ && t.src_cls inside {RC_DBG, RC_SOC}));
	endfunction
	task automatic chk(logic [39:0] seen, logic [39:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// present one line, then look at issue, stall, trap in the answer cycle
	task automatic run(slot_t p, slot_t q, logic [2:0] ex);
		@(negedge clk);
		slot0 = p;
		slot1 = q;
		line_valid = 1'b1;
		rf_store_data = $random(seed);
		d = rf_store_data;
		@(negedge clk);
		line_valid = 1'b0;
		chk({issue, stall, illegal_exc}, ex);
	endtask
	task test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		rstn = 1'b0;
		line_valid = 1'b0;
		slot0 = '0;
		slot1 = '0;
		soc_hold_j = 1'b0;
		soc_hold_k = 1'b0;
		rf_store_data = '0;
		dly = 4'h5;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		a = mk(OP_XFER, UNIT_J, RC_GEN, RC_GEN);
		b = mk(OP_XFER, UNIT_K, RC_GEN, RC_GEN);
		run(a, b, 3'b100);
		chk({j_bus_busy, k_bus_busy}, 2'b11);
		soc_hold_j = 1'b1;
		run(a, b, 3'b010);
		soc_hold_j = 1'b0;
		soc_hold_k = 1'b1;
		run(a, '0, 3'b100);
		chk({j_bus_busy, k_bus_busy}, 2'b10);
		run(a, b, 3'b010);
		soc_hold_k = 1'b0;
		run(a, a, 3'b001);
		s = mk(OP_STORE_SUM, UNIT_J, RC_KREG, RC_GEN);
		run(s, mk(OP_IMM, UNIT_K, RC_GEN, RC_GEN), 3'b001);
		run(s, mk(OP_KARITH, UNIT_K, RC_KREG, RC_KREG), 3'b001);
		$display("test pairing done");
		for (i = 0; i < 5; i++)
			run(mk(OP_XFER, UNIT_J, fs[i], fd[i]), '0, 3'b001);
		s = mk(OP_XFER, UNIT_J, RC_SEQ, RC_DBG);
		s.pred_true = 1'b0;
		s.raw_exc = 1'b1;
		run(s, '0, 3'b100);
		chk(op_exc, 1'b0);
		s.pred_true = 1'b1;
		s.src_cls = RC_GEN;
		run(s, '0, 3'b100);
		chk(op_exc, 1'b1);
		s = mk(OP_IDLE, UNIT_J, RC_GEN, RC_GEN);
		s.low_power_option = 1'b1;
		run(s, '0, 3'b100);
		chk(idle_req, 1'b1);
		s = mk(OP_CORR_ACC, UNIT_K, RC_PATH, RC_PATH);
		s.dst_idx = 5'h3;
		s.acc_idx = 5'h4;
		run(s, '0, 3'b001);
		s.acc_idx = 5'h3;
		run(s, '0, 3'b100);
		$display("test traps done");
		st = mk(OP_STORE, UNIT_J, RC_GEN, RC_GEN);
		ar = mk(OP_ARITH, UNIT_K, RC_GEN, RC_GEN);
		run(st, ar, 3'b100);
		e = d;
		@(negedge clk);
		chk({store_req, store_data}, {1'b1, e});
		run(st, '0, 3'b010);
		chk(store_data, e);
		for (i = 0; i < 20 && store_req !== 1'b0; i++)
			@(negedge clk);
		chk(store_req, 1'b0);
		dly = 4'h0;
		run(st, ar, 3'b100);
		e = d;
		@(negedge clk);
		chk({store_req, store_data}, {1'b1, e});
		@(negedge clk);
		chk(store_req, 1'b0);
		// reset in mid-run drops a pending store
		dly = 4'h5;
		run(st, ar, 3'b100);
		@(negedge clk);
		chk(store_req, 1'b1);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		chk({store_req, store_data, issue, stall, illegal_exc}, 36'h0);
		$display("test store done");
		for (i = 0; i < 40; i++)
		begin
			a = mk(OP_XFER, UNIT_J, cls(), cls());
			b = mk(OP_XFER, UNIT_K, cls(), cls());
			a.pred_true = 1'($random(seed));
			b.pred_true = 1'($random(seed));
			x = bad(a) | bad(b);
			run(a, b, {~x, 1'b0, x});
		end
		$display("test random done");
		test_done();
	end
endmodule // line_legality_test
